// ===== rtl/tmc_timer.sv
// Purpose: 16-bit up timer/counter with buffered wide access, prescaler and trigger reset
// Assumes: clk_i is the instruction clock; compare units share clk_i
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ext_clk_i,
    input wire logic sosc_i,
    input wire logic [3:0] cmp1_mode_i,
    input wire logic [15:0] cmp1_value_i,
    input wire logic [3:0] cmp2_mode_i,
    input wire logic [15:0] cmp2_value_i,
    input wire logic adc_enable_i,
    output logic adc_start_o,
    output logic irq_o,
    output logic [4:0] unit_assign_o,
    output logic [15:0] count_o
);
    tmc_byte_t ctrl_q;
    tmc_byte_t sec_ctrl_q;
    tmc_byte_t hbuf_q;
    tmc_byte_t hbuf_d;
    tmc_byte_t rdata_q;
    tmc_count_t count_q;
    tmc_count_t count_d;
    logic [2:0] pre_q;
    logic [2:0] pre_d;
    logic flag_q;
    logic ien_q;
    logic adc_start_q;
    tmc_src_e src;

    tmc_edge_if edge_if ();

    tmc_edge_det u_edge (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ext_clk_i(ext_clk_i),
        .sosc_i(sosc_i),
        .edge_if(edge_if)
    );

    // prescale terminal count for 1:1, 1:2, 1:4, 1:8
    function automatic logic [2:0] tmc_pre_limit(input logic [1:0] sel);
        tmc_pre_limit = 3'(({1'b0, 2'h0} + 3'h1 << sel) - 3'h1);
    endfunction : tmc_pre_limit

    function automatic logic tmc_is_trigger(input logic assigned, input logic [3:0] mode,
                                            input tmc_count_t value, input tmc_count_t cnt);
        tmc_is_trigger = assigned && (mode == `TMC_MODE_SPECIAL_EVENT) && (cnt == value);
    endfunction : tmc_is_trigger

    // decode
    wire wide = ctrl_q[`TMC_CTRL_WIDE_ACCESS_ENABLE];
    wire counter_on = ctrl_q[`TMC_CTRL_COUNTER_ON];
    wire cs = ctrl_q[`TMC_CTRL_COUNT_SOURCE_SELECT];
    wire osc_en = sec_ctrl_q[`TMC_SEC_OSC_ENABLE];
    wire [1:0] div_sel = ctrl_q[`TMC_CTRL_DIVIDER_MSB:`TMC_CTRL_DIVIDER_LSB];
    wire [1:0] pairing = {ctrl_q[`TMC_CTRL_TIMER_PAIRING_HIGH], ctrl_q[`TMC_CTRL_TIMER_PAIRING_LOW]};
    wire wr_low = wr_i && (addr_i == `TMC_ADDR_COUNT_LOW);
    wire wr_high = wr_i && (addr_i == `TMC_ADDR_COUNT_HIGH);
    wire wr_ctrl = wr_i && (addr_i == `TMC_ADDR_COUNTER_CONTROL);
    wire wr_flags = wr_i && (addr_i == `TMC_ADDR_PERIPHERAL_FLAGS_TWO);
    wire wr_ien = wr_i && (addr_i == `TMC_ADDR_PERIPHERAL_ENABLES_TWO);
    wire wr_sec = wr_i && (addr_i == `TMC_ADDR_SECONDARY_TIMER_CONTROL);
    wire rd_low = rd_i && (addr_i == `TMC_ADDR_COUNT_LOW);
    wire wr_count = wr_low || (wr_high && !wide);

    // unit bit i means compare unit i+1 runs on this counter
    assign unit_assign_o = (pairing == `TMC_PAIR_ALL) ? 5'h1F :
                           (pairing == `TMC_PAIR_TWO_UP) ? 5'h1E :
                           (pairing == `TMC_PAIR_THREE_UP) ? 5'h1C : 5'h00;

    // clock source choice; sync bit matters for both the external and secondary oscillator paths
    assign src = !cs ? TMC_SRC_INSTR : (osc_en ? TMC_SRC_SOSC : TMC_SRC_EXT);
    assign edge_if.sync_disable = ctrl_q[`TMC_CTRL_EXT_SYNC_DISABLE];
    wire src_edge = (src == TMC_SRC_INSTR) ? 1'b1 :
                    (src == TMC_SRC_SOSC) ? edge_if.sosc_rise : edge_if.ext_rise;
    wire pre_hit = src_edge && (pre_q == tmc_pre_limit(div_sel));
    wire advance = counter_on && pre_hit;

    // trigger fires on the tick leaving the compare value, so count runs 0..value
    wire trig1 = advance && tmc_is_trigger(unit_assign_o[0], cmp1_mode_i, cmp1_value_i, count_q);
    wire trig2 = advance && tmc_is_trigger(unit_assign_o[1], cmp2_mode_i, cmp2_value_i, count_q);
    wire trig = trig1 || trig2;
    // a trigger at FFFFh is a reset, not a wrap
    wire wrap = advance && !trig && !wr_count && (count_q == `TMC_COUNT_MAX);

    always_comb begin
        count_d = count_q;
        if (wr_low) begin
            count_d = {wide ? hbuf_q : count_q[15:8], wdata_i};
        end else if (wr_high && !wide) begin
            count_d = {wdata_i, count_q[7:0]};
        end else if (trig) begin
            count_d = `TMC_RST_COUNT;
        end else if (advance) begin
            count_d = count_q + 16'h0001;
        end
    end

    always_comb begin
        hbuf_d = hbuf_q;
        if (wide && wr_high) begin
            hbuf_d = wdata_i;
        end else if (wide && rd_low) begin
            hbuf_d = count_q[15:8];
        end
    end

    always_comb begin
        pre_d = pre_q;
        if (wr_low) begin
            pre_d = `TMC_RST_PRESCALE;
        end else if (counter_on && src_edge) begin
            pre_d = pre_hit ? `TMC_RST_PRESCALE : pre_q + 3'h1;
        end
    end

    // read mux; wide mode hides the live high byte behind the buffer
    wire [7:0] rd_mux =
        (addr_i == `TMC_ADDR_COUNT_LOW) ? count_q[7:0] :
        (addr_i == `TMC_ADDR_COUNT_HIGH) ? (wide ? hbuf_q : count_q[15:8]) :
        (addr_i == `TMC_ADDR_COUNTER_CONTROL) ? ctrl_q :
        (addr_i == `TMC_ADDR_PERIPHERAL_FLAGS_TWO) ? {6'h00, flag_q, 1'b0} :
        (addr_i == `TMC_ADDR_PERIPHERAL_ENABLES_TWO) ? {6'h00, ien_q, 1'b0} :
        (addr_i == `TMC_ADDR_SECONDARY_TIMER_CONTROL) ? sec_ctrl_q : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count_q <= `TMC_RST_COUNT;
            hbuf_q <= `TMC_RST_BYTE;
            pre_q <= `TMC_RST_PRESCALE;
        end else begin
            count_q <= count_d;
            hbuf_q <= hbuf_d;
            pre_q <= pre_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_q <= `TMC_RST_BYTE;
            sec_ctrl_q <= `TMC_RST_BYTE;
            ien_q <= 1'b0;
        end else begin
            ctrl_q <= wr_ctrl ? wdata_i : ctrl_q;
            sec_ctrl_q <= wr_sec ? wdata_i : sec_ctrl_q;
            ien_q <= wr_ien ? wdata_i[`TMC_ENABLES_OVERFLOW_IRQ] : ien_q;
        end
    end

    // a wrap in the clearing cycle still lands
    wire flag_d = wrap || (wr_flags ? wdata_i[`TMC_FLAGS_OVERFLOW] : flag_q);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
            adc_start_q <= 1'b0;
            rdata_q <= `TMC_RST_BYTE;
        end else begin
            flag_q <= flag_d;
            adc_start_q <= trig2 && !wr_count && adc_enable_i;
            rdata_q <= rd_i ? rd_mux : `TMC_RST_BYTE;
        end
    end

    assign rdata_o = rdata_q;
    assign count_o = count_q;
    assign adc_start_o = adc_start_q;
    assign irq_o = flag_q && ien_q;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_low_read_wide;
        rd_i && addr_i == `TMC_ADDR_COUNT_LOW && wide;
    endsequence
    sequence s_high_read_wide;
        rd_i && addr_i == `TMC_ADDR_COUNT_HIGH && wide;
    endsequence

    property p_high_write_buffered;
        wide && wr_high && !advance |=> hbuf_q == $past(wdata_i) && $stable(count_q[15:8]);
    endproperty
    a_high_write_buffered: assert property (p_high_write_buffered)
        else $error("high write in wide mode did not load buffer");

    property p_coherent_read;
        s_low_read_wide ##1 s_high_read_wide |=> rdata_o == $past(count_q[15:8], 2);
    endproperty
    a_coherent_read: assert property (p_coherent_read)
        else $error("high byte read does not match low byte snapshot");

    property p_low_write_transfers;
        wide && wr_low |=> count_q == {$past(hbuf_q), $past(wdata_i)};
    endproperty
    a_low_write_transfers: assert property (p_low_write_transfers)
        else $error("low write did not transfer buffer into high byte");

    property p_wide_read_hides_live;
        s_high_read_wide |=> rdata_o == $past(hbuf_q);
    endproperty
    a_wide_read_hides_live: assert property (p_wide_read_hides_live)
        else $error("wide mode high read returned live byte");

    property p_prescaler_clear;
        wr_low |=> pre_q == 3'h0;
    endproperty
    a_prescaler_clear: assert property (p_prescaler_clear)
        else $error("low write did not clear prescaler");

    property p_high_write_keeps_prescaler;
        wr_high && !pre_hit |=> pre_q == 3'($past(pre_q) + {2'h0, $past(counter_on && src_edge)});
    endproperty
    a_high_write_keeps_prescaler: assert property (p_high_write_keeps_prescaler)
        else $error("high write disturbed prescaler");

    property p_sosc_counts;
        counter_on && cs && osc_en && div_sel == 2'h0 && edge_if.sosc_rise && !wr_count && !trig
            |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_sosc_counts: assert property (p_sosc_counts)
        else $error("secondary oscillator edge did not advance counter");

    property p_wrap_sets_flag;
        wrap |=> count_q == 16'h0000 && flag_q;
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag)
        else $error("wrap did not clear count and set flag");

    property p_flag_latched;
        flag_q && !wr_flags |=> flag_q;
    endproperty
    a_flag_latched: assert property (p_flag_latched)
        else $error("overflow flag dropped without software clear");

    property p_irq_gate;
        !ien_q |-> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

    property p_trigger_reset;
        trig && !wr_count && !wr_flags |=> count_q == 16'h0000 && flag_q == $past(flag_q);
    endproperty
    a_trigger_reset: assert property (p_trigger_reset)
        else $error("trigger reset wrong or touched flag");

    property p_adc_start;
        trig2 && !wr_count && adc_enable_i |=> adc_start_o
            ##1 (!adc_start_o || $past(trig2 && !wr_count && adc_enable_i));
    endproperty
    a_adc_start: assert property (p_adc_start)
        else $error("unit two trigger did not start conversion");

    property p_no_adc_when_off;
        !adc_enable_i |=> !adc_start_o;
    endproperty
    a_no_adc_when_off: assert property (p_no_adc_when_off)
        else $error("conversion started while converter disabled");

    property p_write_beats_trigger;
        trig && wr_low |=> count_q[7:0] == $past(wdata_i);
    endproperty
    a_write_beats_trigger: assert property (p_write_beats_trigger)
        else $error("trigger overrode software write");

    property p_internal_tick;
        counter_on && !cs && div_sel == 2'h0 && !wr_count && !trig |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_internal_tick: assert property (p_internal_tick)
        else $error("internal source missed an instruction cycle");

    property p_off_holds;
        !counter_on && !wr_count |=> count_q == $past(count_q);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("counter moved while off");

    property p_pairing_none;
        pairing == `TMC_PAIR_NONE |-> unit_assign_o == 5'h00 && !trig;
    endproperty
    a_pairing_none: assert property (p_pairing_none)
        else $error("units paired while code is zero");

    property p_narrow_high_write;
        !wide && wr_high |=> count_q[15:8] == $past(wdata_i);
    endproperty
    a_narrow_high_write: assert property (p_narrow_high_write)
        else $error("narrow high write missed live byte");
endmodule : tmc_timer

// ===== inc/tmc_regs.svh
// Purpose: register offsets, field positions, reset values and codes of the 16-bit timer/counter
// Assumes: byte-wide plain register port with a 3-bit address
// Notes: definitions only
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// register offsets
`define TMC_ADDR_COUNT_LOW 3'h0
`define TMC_ADDR_COUNT_HIGH 3'h1
`define TMC_ADDR_COUNTER_CONTROL 3'h2
`define TMC_ADDR_PERIPHERAL_FLAGS_TWO 3'h3
`define TMC_ADDR_PERIPHERAL_ENABLES_TWO 3'h4
`define TMC_ADDR_SECONDARY_TIMER_CONTROL 3'h5

// counter_control fields
`define TMC_CTRL_WIDE_ACCESS_ENABLE 7
`define TMC_CTRL_TIMER_PAIRING_HIGH 6
`define TMC_CTRL_DIVIDER_MSB 5
`define TMC_CTRL_DIVIDER_LSB 4
`define TMC_CTRL_TIMER_PAIRING_LOW 3
`define TMC_CTRL_EXT_SYNC_DISABLE 2
`define TMC_CTRL_COUNT_SOURCE_SELECT 1
`define TMC_CTRL_COUNTER_ON 0

// flag, enable and secondary oscillator fields
`define TMC_FLAGS_OVERFLOW 1
`define TMC_ENABLES_OVERFLOW_IRQ 1
`define TMC_SEC_OSC_ENABLE 3

// reset values
`define TMC_RST_BYTE 8'h00
`define TMC_RST_COUNT 16'h0000
`define TMC_RST_PRESCALE 3'h0

// codes
`define TMC_COUNT_MAX 16'hFFFF
`define TMC_MODE_SPECIAL_EVENT 4'hB
`define TMC_PAIR_ALL 2'h3
`define TMC_PAIR_THREE_UP 2'h2
`define TMC_PAIR_TWO_UP 2'h1
`define TMC_PAIR_NONE 2'h0

`endif

// ===== inc/tmc_pkg.sv
// Purpose: shared types of the 16-bit timer/counter
// Assumes: nothing beyond the register header
// Notes: constants stay in tmc_regs.svh
package tmc_pkg;
    typedef logic [7:0] tmc_byte_t;
    typedef logic [15:0] tmc_count_t;
    typedef logic [2:0] tmc_addr_t;
    typedef enum logic [2:0] {
        TMC_SRC_INSTR = 3'b001,
        TMC_SRC_EXT = 3'b010,
        TMC_SRC_SOSC = 3'b100
    } tmc_src_e;
endpackage : tmc_pkg

// ===== inc/tmc_edge_if.sv
// Purpose: carries rising-edge events of the outside count clocks to the counter
// Assumes: both ends on clk_i
// Notes: sync_disable steers the extra alignment stage
`timescale 1ns/100ps
interface tmc_edge_if;
    logic sync_disable;
    logic ext_rise;
    logic sosc_rise;
    modport src (input sync_disable, output ext_rise, output sosc_rise);
    modport snk (output sync_disable, input ext_rise, input sosc_rise);
endinterface : tmc_edge_if

// ===== rtl/tmc_edge_det.sv
// Purpose: synchronise the external and secondary oscillator pins and find rising edges
// Assumes: pins are asynchronous to clk_i
// Notes: two flip-flops always guard the pins; sync mode adds one aligning stage
`timescale 1ns/100ps
module tmc_edge_det (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ext_clk_i,
    input wire logic sosc_i,
    tmc_edge_if.src edge_if
);
    logic [2:0] ext_q;
    logic [2:0] sosc_q;
    logic ext_rise_q;
    logic sosc_rise_q;
    wire ext_rise_now = ext_q[1] & ~ext_q[2];
    wire sosc_rise_now = sosc_q[1] & ~sosc_q[2];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ext_q <= 3'h0;
            sosc_q <= 3'h0;
            ext_rise_q <= 1'b0;
            sosc_rise_q <= 1'b0;
        end else begin
            ext_q <= {ext_q[1:0], ext_clk_i};
            sosc_q <= {sosc_q[1:0], sosc_i};
            ext_rise_q <= ext_rise_now;
            sosc_rise_q <= sosc_rise_now;
        end
    end

    // bypass skips only the aligning stage; pins still need the metastability guard
    assign edge_if.ext_rise = edge_if.sync_disable ? ext_rise_now : ext_rise_q;
    assign edge_if.sosc_rise = edge_if.sync_disable ? sosc_rise_now : sosc_rise_q;
endmodule : tmc_edge_det

// ===== sim/tmc_pin_src.sv
// Purpose: far-side sources for the external count pin and the secondary oscillator pin
// Assumes: bench raises run_ext_i or run_sosc_i to emit a square wave
// Notes: a burst always ends with the pin low, so no half pulse hangs between bursts
`timescale 1ns/100ps
module tmc_pin_src #(
    parameter int HALF = 4
) (
    input wire logic clk_i,
    input wire logic run_ext_i,
    input wire logic run_sosc_i,
    output logic ext_clk_o,
    output logic sosc_o,
    output logic [7:0] ext_rises_o,
    output logic [7:0] sosc_rises_o
);
    int ph = 0;
    wire logic step = (ph == HALF - 1);
    initial begin
        ext_clk_o = 1'b0;
        sosc_o = 1'b0;
        ext_rises_o = 8'h00;
        sosc_rises_o = 8'h00;
    end
    // rises are counted here so the bench knows the true edge count
    always @(posedge clk_i) begin
        ph <= step ? 0 : ph + 1;
        if (step && (run_ext_i || ext_clk_o)) begin
            ext_clk_o <= !ext_clk_o;
            ext_rises_o <= ext_rises_o + 8'(!ext_clk_o);
        end
        if (step && (run_sosc_i || sosc_o)) begin
            sosc_o <= !sosc_o;
            sosc_rises_o <= sosc_rises_o + 8'(!sosc_o);
        end
    end
endmodule : tmc_pin_src

// ===== sim/tb.sv
// Purpose: self-checking bench of the 16-bit timer/counter
// Assumes: register port answers one cycle after the read strobe
// Notes: one task per scenario; no random stimulus
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tb
    import tmc_pkg::*;
;
    localparam tmc_addr_t A_LO = `TMC_ADDR_COUNT_LOW;
    localparam tmc_addr_t A_HI = `TMC_ADDR_COUNT_HIGH;
    localparam tmc_addr_t A_CTL = `TMC_ADDR_COUNTER_CONTROL;
    localparam tmc_addr_t A_FLG = `TMC_ADDR_PERIPHERAL_FLAGS_TWO;
    localparam tmc_addr_t A_ENA = `TMC_ADDR_PERIPHERAL_ENABLES_TWO;
    localparam tmc_addr_t A_SEC = `TMC_ADDR_SECONDARY_TIMER_CONTROL;
    localparam logic [4:0] PMAP [4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
    logic clk_i, resetn_i, wr_i, rd_i, adc_enable_i, run_ext, run_sosc;
    tmc_addr_t addr_i;
    tmc_byte_t wdata_i, rdata_o;
    logic [3:0] cmp1_mode_i, cmp2_mode_i;
    tmc_count_t cmp1_value_i, cmp2_value_i, count_o;
    logic adc_start_o, irq_o, ext_clk, sosc;
    logic [4:0] unit_assign_o;
    logic [7:0] ext_rises, sosc_rises;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;

    tmc_timer dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk), .sosc_i(sosc), .cmp1_mode_i(cmp1_mode_i),
        .cmp1_value_i(cmp1_value_i), .cmp2_mode_i(cmp2_mode_i), .cmp2_value_i(cmp2_value_i),
        .adc_enable_i(adc_enable_i), .adc_start_o(adc_start_o), .irq_o(irq_o),
        .unit_assign_o(unit_assign_o), .count_o(count_o));
    tmc_pin_src src (.clk_i(clk_i), .run_ext_i(run_ext), .run_sosc_i(run_sosc), .ext_clk_o(ext_clk),
        .sosc_o(sosc), .ext_rises_o(ext_rises), .sosc_rises_o(sosc_rises));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ceiling well above the roughly one thousand cycles the scenarios need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input tmc_count_t seen, input tmc_count_t exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // strobe drops one edge before the next task can raise it again
    task automatic wr(input tmc_addr_t a, input tmc_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(negedge clk_i);
    endtask : wr
    task automatic rd_chk(input tmc_addr_t a, input tmc_byte_t e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        check({8'h00, rdata_o}, {8'h00, e});
    endtask : rd_chk
    // low then high read back to back, as software does a coherent 16-bit read
    task automatic rd_pair(output tmc_byte_t lo, output tmc_byte_t hi);
        @(posedge clk_i);
        addr_i <= A_LO;
        rd_i <= 1'b1;
        @(posedge clk_i);
        addr_i <= A_HI;
        @(negedge clk_i);
        lo = rdata_o;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        hi = rdata_o;
    endtask : rd_pair
    task automatic set16(input tmc_byte_t h, input tmc_byte_t l);
        wr(A_HI, h);
        wr(A_LO, l);
    endtask : set16
    task automatic cyc_to(input tmc_count_t v, output int n);
        n = 0;
        while (count_o !== v && n < 100) begin
            @(negedge clk_i);
            n++;
        end
    endtask : cyc_to
    task automatic wait_cnt(input tmc_count_t v);
        int n;
        cyc_to(v, n);
        check(count_o, v);
    endtask : wait_cnt

    task automatic t_regs;
        check(count_o, 16'h0000);
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
        wr(A_CTL, 8'hF6);
        rd_chk(A_CTL, 8'hF6);
        wr(A_SEC, 8'h5A);
        rd_chk(A_SEC, 8'h5A);
        wr(3'h6, 8'hFF);
        rd_chk(3'h6, 8'h00);
        wr(A_CTL, 8'h00);
        wr(A_SEC, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_bytes;
        tmc_byte_t lo, hi;
        set16(8'h12, 8'hFF);
        check(count_o, 16'h12FF);
        wr(A_CTL, 8'h80);
        wr(A_HI, 8'hAB);
        check(count_o, 16'h12FF);
        rd_chk(A_HI, 8'hAB);
        wr(A_LO, 8'hCD);
        check(count_o, 16'hABCD);
        wr(A_CTL, 8'h00);
        wr(A_HI, 8'h34);
        rd_chk(A_HI, 8'h34);
        wr(A_CTL, 8'h80);
        rd_chk(A_HI, 8'hAB);
        rd_chk(A_LO, 8'hCD);
        rd_chk(A_HI, 8'h34);
        wr(A_HI, 8'h12);
        wr(A_LO, 8'hF0);
        wr(A_CTL, 8'h81);
        wait_cnt(16'h12FE);
        // low byte read at 12FFh; the high read lands after the carry to 13h
        rd_pair(lo, hi);
        check({hi, lo}, 16'h12FF);
        wr(A_CTL, 8'h00);
        $display("test bytes done");
    endtask : t_bytes
    task automatic t_ovf;
        set16(8'hFF, 8'hF0);
        wr(A_ENA, 8'h02);
        wr(A_CTL, 8'h01);
        wait_cnt(16'hFFFF);
        @(negedge clk_i);
        check(count_o, 16'h0000);
        check({15'h0, irq_o}, 16'h0001);
        wr(A_CTL, 8'h00);
        rd_chk(A_FLG, 8'h02);
        wr(A_ENA, 8'h00);
        check({15'h0, irq_o}, 16'h0000);
        rd_chk(A_FLG, 8'h02);
        wr(A_FLG, 8'h00);
        rd_chk(A_FLG, 8'h00);
        $display("test overflow done");
    endtask : t_ovf
    task automatic t_div;
        int n, d1;
        for (int c = 0; c < 4; c++) begin
            wr(A_CTL, 8'h00);
            set16(8'h00, 8'h00);
            wr(A_CTL, 8'(c * 16 + 1));
            wait_cnt(16'h0001);
            cyc_to(16'h0002, n);
            check(16'(n), 16'(1 << c));
        end
        wr(A_LO, 8'h00);
        cyc_to(16'h0001, d1);
        repeat (3) @(negedge clk_i);
        wr(A_LO, 8'h00);
        cyc_to(16'h0001, n);
        check(16'(n), 16'(d1));
        repeat (3) @(negedge clk_i);
        wr(A_HI, 8'h00);
        cyc_to(16'h0002, n);
        check(16'(n + 5), 16'h0008);
        wr(A_CTL, 8'h00);
        set16(8'h00, 8'h05);
        repeat (12) @(negedge clk_i);
        check(count_o, 16'h0005);
        $display("test divider done");
    endtask : t_div
    task automatic run_pins(input tmc_byte_t ctl, input tmc_byte_t sec, input logic use_sosc, input logic cnt);
        logic [7:0] e;
        wr(A_CTL, 8'h00);
        set16(8'h00, 8'h00);
        wr(A_SEC, sec);
        wr(A_CTL, ctl);
        e = use_sosc ? sosc_rises : ext_rises;
        @(posedge clk_i);
        run_ext <= !use_sosc;
        run_sosc <= use_sosc;
        repeat (60) @(posedge clk_i);
        run_ext <= 1'b0;
        run_sosc <= 1'b0;
        repeat (16) @(negedge clk_i);
        e = (use_sosc ? sosc_rises : ext_rises) - e;
        check(count_o, cnt ? {8'h00, e} : 16'h0000);
    endtask : run_pins
    task automatic t_ext;
        run_pins(8'h03, 8'h00, 1'b0, 1'b1);
        run_pins(8'h07, 8'h00, 1'b0, 1'b1);
        run_pins(8'h03, 8'h08, 1'b1, 1'b1);
        run_pins(8'h03, 8'h00, 1'b1, 1'b0);
        wr(A_SEC, 8'h00);
        $display("test pins done");
    endtask : t_ext
    task automatic run_trig(input tmc_byte_t ctl, input logic [3:0] m1, input logic [3:0] m2, input logic adc,
        input tmc_count_t v, input tmc_count_t st, output tmc_count_t mx, output int rs, output int ad);
        tmc_count_t prev;
        wr(A_CTL, 8'h00);
        set16(st[15:8], st[7:0]);
        wr(A_FLG, 8'h00);
        @(posedge clk_i);
        cmp1_mode_i <= m1;
        cmp2_mode_i <= m2;
        cmp1_value_i <= v;
        cmp2_value_i <= v;
        adc_enable_i <= adc;
        wr(A_CTL, ctl); // internal source only while triggers run
        mx = 16'h0000;
        rs = 0;
        ad = 0;
        prev = count_o;
        repeat (48) begin
            @(negedge clk_i);
            if (count_o > mx) mx = count_o;
            if (count_o === 16'h0000 && prev !== 16'h0000) rs++;
            if (adc_start_o === 1'b1) ad++;
            prev = count_o;
        end
        wr(A_CTL, 8'h00);
    endtask : run_trig
    task automatic t_trig;
        tmc_count_t mx;
        int rs, ad;
        for (int c = 0; c < 4; c++) begin
            wr(A_CTL, 8'((c / 2) * 64 + (c % 2) * 8));
            check({11'h0, unit_assign_o}, {11'h0, PMAP[c]});
        end
        run_trig(8'h49, 4'hB, 4'h0, 1'b1, 16'h0009, 16'h0000, mx, rs, ad);
        check(mx, 16'h0009);
        check(16'(ad), 16'h0000);
        // low write lands in the very cycle the count sits on the compare value
        wr(A_CTL, 8'h49);
        wait_cnt(16'h0008);
        wr(A_LO, 8'h55);
        check(count_o, 16'h0055);
        run_trig(8'h49, 4'h0, 4'hB, 1'b1, 16'h0009, 16'h0000, mx, rs, ad);
        check(mx, 16'h0009);
        check(16'(ad), 16'(rs));
        check(16'(rs > 2), 16'h0001);
        run_trig(8'h41, 4'hB, 4'h0, 1'b0, 16'h0009, 16'h0000, mx, rs, ad);
        check(16'(mx > 16'h0009), 16'h0001);
        run_trig(8'h09, 4'hB, 4'hB, 1'b0, 16'h0009, 16'h0000, mx, rs, ad);
        check(mx, 16'h0009);
        check(16'(ad), 16'h0000);
        run_trig(8'h49, 4'hA, 4'h0, 1'b0, 16'h0009, 16'h0000, mx, rs, ad);
        check(16'(mx > 16'h0009), 16'h0001);
        run_trig(8'h49, 4'hB, 4'h0, 1'b0, 16'hFFFF, 16'hFFF8, mx, rs, ad);
        check(16'(rs > 0), 16'h0001);
        rd_chk(A_FLG, 8'h00);
        $display("test trigger done");
    endtask : t_trig

    initial begin
        resetn_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        adc_enable_i = 1'b0;
        run_ext = 1'b0;
        run_sosc = 1'b0;
        cmp1_mode_i = 4'h0;
        cmp2_mode_i = 4'h0;
        cmp1_value_i = 16'h0000;
        cmp2_value_i = 16'h0000;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_bytes();
        t_ovf();
        t_div();
        t_ext();
        t_trig();
        end_of_test();
    end
endmodule : tb
